// [sim/msn_peer.sv]
// Peer port model: per-lane receive status and negotiation results.
// Assumes the bench commands it through its tasks.
`timescale 1ns/1ns
module msn_peer #(
  parameter bit SLOW = 1'b0
) (
  // Clock
  input wire logic clk_i,
  // Lane status
  output logic [3:0] los_o,
  output logic [3:0] sync_o,
  output logic [3:0] word_o,
  output logic [3:0] cv_o,
  output logic [3:0] par_o,
  output logic [7:0] rxspd_o,
  // Results
  output logic [3:0] done_o,
  output logic [7:0] spd_o,
  output logic init_done_o,
  output logic init_ok_o
);
  logic [3:0] cv_m;
  logic ph;
  // No signal at power on
  initial
  begin
    {los_o, sync_o, word_o, cv_o, par_o, done_o, cv_m} = {4'hF, 24'h0};
    {rxspd_o, spd_o, init_done_o, init_ok_o, ph} = 19'h0;
  end
  // Word and violation strobes only while in sync
  always @(posedge clk_i)
  begin
    ph <= ~ph;
    word_o <= sync_o & {4{~(SLOW & ph)}};
    cv_o <= cv_m & sync_o;
  end
  // Signal present on all lanes at given speeds
  task automatic sig(input logic [7:0] s, input logic [3:0] c);
    @(posedge clk_i);
    {spd_o, rxspd_o, cv_m, sync_o, los_o} <= {s, s, c, 8'hF0};
  endtask : sig
  // Per-lane results, each lane on its own
  task automatic done(input logic [3:0] p, input logic [3:0] d);
    @(posedge clk_i);
    par_o <= p;
    done_o <= d;
  endtask : done
  // Aggregate initialization outcome
  task automatic init(input logic ok);
    @(posedge clk_i);
    {init_done_o, init_ok_o} <= {1'b1, ok};
    @(posedge clk_i);
    init_done_o <= 1'b0;
  endtask : init
  // Lanes 0-1 lose signal, 2-3 lose sync
  task automatic drop(input logic [3:0] m);
    @(posedge clk_i);
    sync_o <= sync_o & ~(m & 4'hC);
    los_o <= los_o | (m & 4'h3);
  endtask : drop
endmodule : msn_peer

// [sim/msn_props.sv]
// Port checker for the multilane speed negotiation block.
// Assumes a bind onto the top module; lane outputs other than lane_par_req_o, out_of_scope_o and link_128_o are registered.
`timescale 1ns/1ns
module msn_props #(
  parameter int LANES = 4,
  parameter logic [1:0] SPEED_32G = 2'h3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Lane inputs
  input wire logic [LANES-1:0] lane_los_i,
  input wire logic [LANES-1:0] lane_sync_i,
  input wire logic [LANES-1:0] lane_rx_par_i,
  input wire logic [2*LANES-1:0] lane_speed_i,
  input wire logic link_init_done_i,
  input wire logic link_init_ok_i,
  // Lane outputs
  input wire logic [LANES-1:0] lane_par_req_o,
  input wire logic [LANES-1:0] out_of_scope_o,
  input wire logic [LANES-1:0] lane_renegotiate_o,
  input wire logic [LANES-1:0] lane_enable_o,
  input wire logic [LANES-1:0] watchdog_start_o,
  input wire logic link_128_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Lanes with loss of signal or sync
  wire logic [LANES-1:0] bad = lane_los_i | ~lane_sync_i;

  a_par_all_lanes: assert property (
    lane_par_req_o == '0 || lane_par_req_o == '1)
    else $error("request bit differs across lanes");
  a_oos_cause: assert property (
    (out_of_scope_o & ~bad) == '0)
    else $error("event without loss");
  a_oos_in_128: assert property (
    link_128_o |-> out_of_scope_o == bad)
    else $error("event missing on aggregate link");
  a_agg_entry: assert property (
    $rose(link_128_o) |-> $past(link_init_done_i && link_init_ok_i)
      && lane_enable_o == '1)
    else $error("aggregate entered without init");
  a_fail_no_128: assert property (
    link_init_done_i && !link_init_ok_i && !link_128_o |=> !link_128_o)
    else $error("aggregate entered after failed init");
  a_indiv_32g: assert property (
    $rose(lane_enable_o[0]) && !link_128_o
      |-> !$past(lane_rx_par_i[0] && lane_speed_i[1:0] == SPEED_32G))
    else $error("individual 32G lane with request set");
  a_reneg_cause: assert property (
    $rose(lane_renegotiate_o[0]) && lane_renegotiate_o != '1
      |-> $past(lane_enable_o[0] && bad[0]))
    else $error("lane renegotiated without failure");
  a_restart_all: assert property (
    lane_renegotiate_o == '1 |=> lane_enable_o == '0)
    else $error("restart kept lanes enabled");
  a_wdog_start: assert property (
    link_128_o && $fell(lane_sync_i[2]) |-> ##[1:2] watchdog_start_o[2])
    else $error("watchdog not started");

  c_agg: cover property ($rose(link_128_o));
  c_restart: cover property (lane_renegotiate_o == '1);
  c_wdog: cover property (watchdog_start_o[2]);
endmodule : msn_props

// [sim/multilane_speed_negotiation_test.sv]
// Bench for the multilane speed negotiation block.
// Assumes the peer model and the bound port checker.
`timescale 1ns/1ns
module multilane_speed_negotiation_test;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic pready_o, pslverr_o, link_init_done_i, link_init_ok_i;
  logic link_128_o;
  logic [3:0] lane_los_i, lane_sync_i, lane_word_i, lane_cv_i;
  logic [3:0] lane_rx_par_i, lane_neg_done_i, lane_par_req_o;
  logic [3:0] out_of_scope_o, lane_renegotiate_o, lane_enable_o;
  logic [3:0] watchdog_start_o;
  logic [7:0] lane_rx_speed_i, lane_speed_i;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;

  multilane_speed_negotiation #(.REQ_WORDS(8), .MONITOR_CYC(64),
    .ATOM_CYC(64)) multilane_speed_negotiation_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .lane_los_i(lane_los_i),
    .lane_sync_i(lane_sync_i), .lane_word_i(lane_word_i),
    .lane_cv_i(lane_cv_i), .lane_rx_par_i(lane_rx_par_i),
    .lane_rx_speed_i(lane_rx_speed_i), .lane_neg_done_i(lane_neg_done_i),
    .lane_speed_i(lane_speed_i), .link_init_done_i(link_init_done_i),
    .link_init_ok_i(link_init_ok_i), .lane_par_req_o(lane_par_req_o),
    .out_of_scope_o(out_of_scope_o),
    .lane_renegotiate_o(lane_renegotiate_o),
    .lane_enable_o(lane_enable_o), .watchdog_start_o(watchdog_start_o),
    .link_128_o(link_128_o));

  msn_peer msn_peer_inst (.clk_i(clk_i), .los_o(lane_los_i),
    .sync_o(lane_sync_i), .word_o(lane_word_i), .cv_o(lane_cv_i),
    .par_o(lane_rx_par_i), .rxspd_o(lane_rx_speed_i),
    .done_o(lane_neg_done_i), .spd_o(lane_speed_i),
    .init_done_o(link_init_done_i), .init_ok_o(link_init_ok_i));

  // Clock and hang limit
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic s);
    @(posedge clk_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    {r, s} = {prdata_o, pslverr_o};
    {psel_i, penable_i} <= 2'b00;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic s;
    apb(1'b1, a, d, r, s);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, m);
    logic [31:0] r;
    logic s;
    apb(1'b0, a, 32'h0, r, s);
    chk(r & m, e);
    chk({31'h0, s}, {31'h0, a > msn_pkg::OFF_DELAY});
  endtask : rdc

  // Status read until it matches or tries run out
  task automatic poll(input logic [31:0] e, m);
    logic [31:0] r;
    logic s;
    for (int i = 0; i < 40; i++)
    begin
      apb(1'b0, msn_pkg::OFF_STATUS, 32'h0, r, s);
      if ((r & m) === e) break;
    end
    chk(r & m, e);
  endtask : poll

  // Next lower index in a mask, else the highest
  function automatic logic [1:0] nl(input logic [3:0] m, input int a);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 0; i < 4; i++) if (m[i]) r = i[1:0];
    for (int i = 0; i < a; i++) if (m[i]) r = i[1:0];
    return r;
  endfunction : nl

  // Main sequence
  initial
  begin
    logic [31:0] e;
    logic hit;
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rdc(msn_pkg::OFF_SPEED, 32'hFF, 32'hFF);
    rdc(msn_pkg::OFF_LIM_A, 32'h03E803E8, '1);
    rdc(msn_pkg::OFF_DELAY, 32'h000A0005, '1);
    rdc(8'h20, 32'h0, '1);
    wr(msn_pkg::OFF_SPEED, 32'hFA);
    rdc(msn_pkg::OFF_SPEED, 32'hFF, 32'hFF);
    wr(msn_pkg::OFF_CTRL, 32'h10);
    wr(msn_pkg::OFF_SPEED, 32'hFA);
    rdc(msn_pkg::OFF_SPEED, 32'hFA, 32'hFF);
    for (int a = 0; a < 4; a++)
    begin
      wr(msn_pkg::OFF_QUERY, 32'(a));
      e = {26'h0, nl(4'hF, a), nl(4'hA, a), a[1:0]};
      rdc(msn_pkg::OFF_QUERY, e, 32'h3F);
    end
    wr(msn_pkg::OFF_SPEED, 32'hFF);
    wr(msn_pkg::OFF_CTRL, 32'h9);
    @(posedge clk_i);
    chk(32'(lane_par_req_o), 32'hF);
    // Violations on lane 0 spoil its test
    msn_peer_inst.sig(8'hAA, 4'h1);
    repeat (200) @(posedge clk_i);
    poll(32'h00400E00, 32'h00F00F00);
    msn_peer_inst.sig(8'hAA, 4'h0);
    repeat (200) @(posedge clk_i);
    poll(32'h00400F00, 32'h00F00F00);
    // Aggregate link, then sync loss in operation
    msn_peer_inst.sig(8'hFF, 4'h0);
    msn_peer_inst.done(4'hF, 4'hF);
    poll(32'h1, 32'h7);
    msn_peer_inst.init(1'b1);
    poll(32'h0F000002, 32'h0F000007);
    msn_peer_inst.drop(4'h4);
    hit = 1'b0;
    repeat (4) @(posedge clk_i) hit |= watchdog_start_o[2];
    chk(32'(hit), 32'h1);
    chk(32'(out_of_scope_o), 32'h4);
    chk(32'(link_128_o), 32'h1);
    // Failed init, then loss leads to restart
    msn_peer_inst.done(4'hF, 4'h0);
    wr(msn_pkg::OFF_CTRL, 32'h7);
    poll(32'h0, 32'h7);
    msn_peer_inst.sig(8'hFF, 4'h0);
    msn_peer_inst.done(4'hF, 4'hF);
    poll(32'h1, 32'h7);
    msn_peer_inst.init(1'b0);
    poll(32'h3, 32'h7);
    msn_peer_inst.done(4'hF, 4'h0);
    msn_peer_inst.drop(4'h1);
    poll(32'h0, 32'h7);
    // Individual lanes: 32G only where request was clear
    msn_peer_inst.sig(8'hFF, 4'h0);
    msn_peer_inst.done(4'hD, 4'hF);
    poll(32'h02000005, 32'h0F000007);
    chk(32'(link_128_o), 32'h0);
    msn_peer_inst.done(4'hD, 4'h0);
    wr(msn_pkg::OFF_CTRL, 32'h7);
    poll(32'h0, 32'h7);
    msn_peer_inst.sig(8'h9B, 4'h0);
    msn_peer_inst.done(4'h0, 4'hF);
    poll(32'h0F000005, 32'h0F000007);
    msn_peer_inst.drop(4'h1);
    poll(32'h0E000015, 32'h0E0000F7);
    msn_peer_inst.done(4'h0, 4'h0);
    msn_peer_inst.drop(4'hE);
    poll(32'h0, 32'h0F000007);
    print_verdict();
  end
endmodule : multilane_speed_negotiation_test

bind multilane_speed_negotiation msn_props #(.LANES(LANES),
  .SPEED_32G(SPEED_32G)) msn_props_inst (.clk_i(clk_i),
  .reset_n_i(reset_n_i), .lane_los_i(lane_los_i),
  .lane_sync_i(lane_sync_i), .lane_rx_par_i(lane_rx_par_i),
  .lane_speed_i(lane_speed_i), .link_init_done_i(link_init_done_i),
  .link_init_ok_i(link_init_ok_i), .lane_par_req_o(lane_par_req_o),
  .out_of_scope_o(out_of_scope_o),
  .lane_renegotiate_o(lane_renegotiate_o),
  .lane_enable_o(lane_enable_o), .watchdog_start_o(watchdog_start_o),
  .link_128_o(link_128_o));

// [verilog/msn_pkg.sv]
// Shared constants for the multilane speed negotiation controller.
// Assumes a 125 MHz system clock and a 32-bit APB register port.
package msn_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_SPEED = 8'h08;
  localparam logic [7:0] OFF_QUERY = 8'h0C;
  localparam logic [7:0] OFF_LIM_A = 8'h10;
  localparam logic [7:0] OFF_LIM_B = 8'h14;
  localparam logic [7:0] OFF_DELAY = 8'h18;
  // Control bits
  localparam int CTRL_PAR_REQ = 0;
  localparam int CTRL_RESTART = 1;
  localparam int CTRL_CV_COUNT = 2;
  localparam int CTRL_CODE_64B = 3;
  localparam int CTRL_MASTER = 4;
  localparam int CTRL_TEST_GO = 5;
  localparam int CTRL_ATOM = 6;
  localparam int CTRL_TMR_CLR = 8;
  localparam int CTRL_REC_CLR = 12;
  localparam int CTRL_LANE = 16;
  // Status field positions
  localparam int ST_STATE = 0;
  localparam int ST_FAILED = 4;
  localparam int ST_PASS = 8;
  localparam int ST_DONE = 12;
  localparam int ST_RESULT = 13;
  localparam int ST_ATOM_LATE = 14;
  localparam int ST_EXPIRED = 16;
  localparam int ST_RECORDED = 20;
  localparam int ST_ENABLE = 24;
  // Speed and query fields
  localparam int SPD_SUPPORTED = 4;
  localparam int Q_TX_NEXT = 2;
  localparam int Q_RX_NEXT = 4;
  // Elapsed-time timer indices
  localparam int TMR_TX = 0;
  localparam int TMR_NEG = 1;
  localparam int TMR_SYNC = 2;
  localparam int TMR_NC = 3;
  // Reset values
  localparam logic [15:0] LIM_RST = 16'h03E8;
  localparam logic [15:0] DLY_MIN_RST = 16'h0005;
  localparam logic [15:0] DLY_MAX_RST = 16'h000A;
  localparam logic [3:0] SPEED_MASK_RST = 4'hF;
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int US_TICK_CYC = CLK_MHZ;
  localparam int MONITOR_MAX_US = 100;
  localparam int MONITOR_MAX_CYC = MONITOR_MAX_US * CLK_MHZ;
  localparam int ATOM_MAX_US = 100;
  localparam int ATOM_MAX_CYC = ATOM_MAX_US * CLK_MHZ;
  // Link level states
  typedef enum logic [2:0] {
    LS_NEGOTIATE, LS_INIT128, LS_NORMAL128, LS_FAIL128, LS_RESTART,
    LS_INDIVIDUAL
  } link_state_t;
endpackage : msn_pkg

// [verilog/multilane_speed_negotiation.sv]
// Multilane speed negotiation control with APB register port.
// Assumes lane status inputs synchronous to clk_i and an APB master.
`timescale 1ns/1ns
module multilane_speed_negotiation #(
  parameter int LANES = 4,
  parameter logic [1:0] SPEED_32G = 2'h3,
  parameter int REQ_WORDS = 64,
  parameter int MONITOR_CYC = msn_pkg::MONITOR_MAX_CYC,
  parameter int ATOM_CYC = msn_pkg::ATOM_MAX_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Lane receive status
  input wire logic [LANES-1:0] lane_los_i,
  input wire logic [LANES-1:0] lane_sync_i,
  input wire logic [LANES-1:0] lane_word_i,
  input wire logic [LANES-1:0] lane_cv_i,
  input wire logic [LANES-1:0] lane_rx_par_i,
  input wire logic [2*LANES-1:0] lane_rx_speed_i,
  // Lane negotiation results
  input wire logic [LANES-1:0] lane_neg_done_i,
  input wire logic [2*LANES-1:0] lane_speed_i,
  // Aggregate link initialization
  input wire logic link_init_done_i,
  input wire logic link_init_ok_i,
  // Lane control
  output logic [LANES-1:0] lane_par_req_o,
  output logic [LANES-1:0] out_of_scope_o,
  output logic [LANES-1:0] lane_renegotiate_o,
  output logic [LANES-1:0] lane_enable_o,
  output logic [LANES-1:0] watchdog_start_o,
  output logic link_128_o
);
  msn_pkg::link_state_t state;
  msn_pkg::link_state_t next_state;
  logic [31:0] ctrl;
  logic [3:0] tx_list;
  logic [3:0] supported;
  logic [1:0] query_arg;
  logic [15:0] lim [4];
  logic [15:0] tmr [4];
  logic [15:0] dly_min;
  logic [15:0] dly_max;
  logic [15:0] dly_cnt;
  logic dly_busy;
  logic dly_pass;
  logic test_done;
  logic test_pass;
  logic [15:0] atom_cnt;
  logic atom_late;
  logic [7:0] us_div;
  logic us_tick;
  logic [3:0] recorded;
  logic [LANES-1:0] failed;
  logic [LANES-1:0] done_q;
  logic [LANES-1:0] sync_q;
  logic [LANES-1:0] oos;
  logic [LANES-1:0] mon_pass;
  logic [LANES-1:0] mon_done;
  logic [LANES-1:0] operating;
  logic [LANES-1:0] allowed;
  logic all_done;
  logic all_par;
  logic all_32g;
  logic [1:0] lane_sel;
  logic wr;
  logic rd;
  logic hit;
  logic [31:0] status;
  logic [3:0] next_expired;

  // Next lower speed in a mask, wrapping to its highest speed
  function automatic logic [1:0] next_lower(input logic [1:0] s,
    input logic [3:0] m);
    logic [1:0] r;
    r = s;
    for (int i = 0; i < 4; i++)
      if (m[i])
        r = 2'(i);
    for (int i = 0; i < 4; i++)
      if (m[i] && (i < int'(s)))
        r = 2'(i);
    return r;
  endfunction : next_lower

  // One pass monitor per lane
  for (genvar g = 0; g < LANES; g++)
  begin : g_mon
    sync_pass_monitor #(
      .REQ_WORDS(REQ_WORDS),
      .WIN_CYC(MONITOR_CYC)
    ) u_mon (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .word_i(lane_word_i[g]),
      .sync_i(lane_sync_i[g]),
      .cv_i(lane_cv_i[g]),
      .cv_count_i(ctrl[msn_pkg::CTRL_CV_COUNT]
        || ctrl[msn_pkg::CTRL_CODE_64B]),
      .pass_o(mon_pass[g]),
      .done_o(mon_done[g])
    );
  end

  // APB decode, zero wait states
  assign wr = psel_i && penable_i && pwrite_i;
  assign rd = psel_i && !penable_i && !pwrite_i;
  assign pready_o = 1'b1;
  always_comb
  begin
    case (paddr_i)
      msn_pkg::OFF_CTRL, msn_pkg::OFF_STATUS, msn_pkg::OFF_SPEED,
      msn_pkg::OFF_QUERY, msn_pkg::OFF_LIM_A, msn_pkg::OFF_LIM_B,
      msn_pkg::OFF_DELAY: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr_o = psel_i && penable_i && !hit;

  // Lane level events and aggregate conditions
  assign oos = lane_los_i | ~lane_sync_i;
  assign all_done = &lane_neg_done_i;
  assign all_par = &lane_rx_par_i;
  assign lane_sel = ctrl[msn_pkg::CTRL_LANE +: 2];
  always_comb
  begin
    all_32g = 1'b1;
    for (int i = 0; i < LANES; i++)
    begin
      all_32g = all_32g && (lane_speed_i[2*i +: 2] == SPEED_32G);
      allowed[i] = (lane_speed_i[2*i +: 2] != SPEED_32G)
        || !lane_rx_par_i[i];
    end
  end
  assign operating = (state == msn_pkg::LS_NORMAL128) ? {LANES{1'b1}}
    : (state == msn_pkg::LS_INDIVIDUAL) ? (lane_enable_o & ~failed)
    : {LANES{1'b0}};

  // Parallel-lane request goes out identically on every lane
  assign lane_par_req_o = {LANES{ctrl[msn_pkg::CTRL_PAR_REQ]}};
  assign link_128_o = (state == msn_pkg::LS_NORMAL128);

  // Out-of-scope events while the link is aggregated
  always_comb
  begin
    case (state)
      msn_pkg::LS_INIT128, msn_pkg::LS_NORMAL128, msn_pkg::LS_FAIL128:
        out_of_scope_o = oos;
      default:
        out_of_scope_o = {LANES{1'b0}};
    endcase
  end

  // Link level state transitions, one cycle per step
  always_comb
  begin
    next_state = state;
    case (state)
      msn_pkg::LS_NEGOTIATE:
        if (all_done && all_par && all_32g)
          next_state = msn_pkg::LS_INIT128;
        else if (all_done)
          next_state = msn_pkg::LS_INDIVIDUAL;
      msn_pkg::LS_INIT128:
        if (link_init_done_i)
          next_state = link_init_ok_i ? msn_pkg::LS_NORMAL128
            : msn_pkg::LS_FAIL128;
      msn_pkg::LS_FAIL128:
        if (|oos)
          next_state = msn_pkg::LS_RESTART;
      msn_pkg::LS_INDIVIDUAL:
        if (&(failed | (oos & operating)))
          next_state = msn_pkg::LS_RESTART;
      msn_pkg::LS_RESTART:
        next_state = msn_pkg::LS_NEGOTIATE;
      default:
        next_state = state;
    endcase
    if (ctrl[msn_pkg::CTRL_RESTART])
      next_state = msn_pkg::LS_RESTART;
  end

  // Link state register
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state <= msn_pkg::LS_NEGOTIATE;
    else
      state <= next_state;
  end

  // Per-lane failure tracking and renegotiation requests
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      failed <= '0;
      done_q <= '0;
      lane_renegotiate_o <= '0;
      lane_enable_o <= '0;
    end
    else
    begin
      done_q <= lane_neg_done_i;
      lane_renegotiate_o <= '0;
      if (next_state == msn_pkg::LS_RESTART)
      begin
        failed <= '0;
        lane_enable_o <= '0;
        lane_renegotiate_o <= '1;
      end
      else if (state == msn_pkg::LS_NEGOTIATE
        && next_state == msn_pkg::LS_INDIVIDUAL)
        lane_enable_o <= allowed;
      else if (state == msn_pkg::LS_INIT128
        && next_state == msn_pkg::LS_NORMAL128)
        lane_enable_o <= '1;
      else if (state == msn_pkg::LS_INDIVIDUAL)
        for (int i = 0; i < LANES; i++)
        begin
          if (oos[i] && operating[i])
          begin
            failed[i] <= 1'b1;
            lane_renegotiate_o[i] <= 1'b1;
          end
          else if (failed[i] && lane_neg_done_i[i] && !done_q[i])
          begin
            failed[i] <= 1'b0;
            lane_enable_o[i] <= allowed[i];
          end
        end
    end
  end

  // Watchdog start on sync loss in normal operation
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sync_q <= '0;
      watchdog_start_o <= '0;
    end
    else
    begin
      sync_q <= lane_sync_i;
      watchdog_start_o <= sync_q & ~lane_sync_i & operating;
    end
  end

  // Recorded receive speeds, one bit per speed index
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      recorded <= 4'h0;
    else
    begin
      if (ctrl[msn_pkg::CTRL_REC_CLR])
        recorded <= 4'h0;
      for (int i = 0; i < LANES; i++)
        if (mon_done[i] && mon_pass[i])
          recorded[lane_rx_speed_i[2*i +: 2]] <= 1'b1;
    end
  end

  // Microsecond tick for the elapsed-time timers
  assign us_tick = (us_div == 8'(msn_pkg::US_TICK_CYC - 1));
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      us_div <= 8'h00;
    else if (us_tick)
      us_div <= 8'h00;
    else
      us_div <= us_div + 8'h01;
  end

  // Elapsed-time timers, cleared by software, saturating
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      for (int i = 0; i < 4; i++)
        tmr[i] <= 16'h0000;
    else
      for (int i = 0; i < 4; i++)
        if (ctrl[msn_pkg::CTRL_TMR_CLR + i])
          tmr[i] <= 16'h0000;
        else if (i == msn_pkg::TMR_SYNC && !lane_sync_i[lane_sel])
          tmr[i] <= 16'h0000;
        else if (us_tick && tmr[i] != 16'hFFFF)
          tmr[i] <= tmr[i] + 16'h0001;
  end
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      next_expired[i] = tmr[i] >= lim[i];
  end

  // Delay-and-test: sample the pass result from the start until the count exceeds dly_min
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      dly_busy <= 1'b0;
      dly_cnt <= 16'h0000;
      dly_pass <= 1'b0;
      test_done <= 1'b0;
      test_pass <= 1'b0;
    end
    else if (ctrl[msn_pkg::CTRL_TEST_GO])
    begin
      dly_busy <= 1'b1;
      dly_cnt <= 16'h0000;
      dly_pass <= 1'b0;
      test_done <= 1'b0;
    end
    else if (dly_busy)
    begin
      if (mon_done[lane_sel] && mon_pass[lane_sel])
        dly_pass <= 1'b1;
      if (us_tick)
        dly_cnt <= dly_cnt + 16'h0001;
      if (dly_cnt > dly_min)
      begin
        dly_busy <= 1'b0;
        test_done <= 1'b1;
        test_pass <= dly_pass || (mon_done[lane_sel]
          && mon_pass[lane_sel]);
      end
    end
  end

  // Step timer: flags a step left open too long
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      atom_cnt <= 16'h0000;
      atom_late <= 1'b0;
    end
    else if (ctrl[msn_pkg::CTRL_ATOM])
    begin
      atom_cnt <= 16'h0000;
      atom_late <= 1'b0;
    end
    else if (atom_cnt >= 16'(ATOM_CYC - 1))
      atom_late <= 1'b1;
    else
      atom_cnt <= atom_cnt + 16'h0001;
  end

  // Control register, pulse bits self-clear
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ctrl <= 32'h0000_0000;
    else if (wr && paddr_i == msn_pkg::OFF_CTRL)
      ctrl <= pwdata_i;
    else
    begin
      ctrl[msn_pkg::CTRL_RESTART] <= 1'b0;
      ctrl[msn_pkg::CTRL_TEST_GO] <= 1'b0;
      ctrl[msn_pkg::CTRL_ATOM] <= 1'b0;
      ctrl[msn_pkg::CTRL_REC_CLR] <= 1'b0;
      ctrl[msn_pkg::CTRL_TMR_CLR +: 4] <= 4'h0;
    end
  end

  // Speed lists, limits, delay window and query argument
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tx_list <= msn_pkg::SPEED_MASK_RST;
      supported <= msn_pkg::SPEED_MASK_RST;
      query_arg <= 2'h0;
      dly_min <= msn_pkg::DLY_MIN_RST;
      dly_max <= msn_pkg::DLY_MAX_RST;
      for (int i = 0; i < 4; i++)
        lim[i] <= msn_pkg::LIM_RST;
    end
    else if (wr)
      case (paddr_i)
        msn_pkg::OFF_SPEED:
        begin
          supported <= pwdata_i[msn_pkg::SPD_SUPPORTED +: 4];
          if (ctrl[msn_pkg::CTRL_MASTER])
            tx_list <= pwdata_i[3:0];
        end
        msn_pkg::OFF_QUERY: query_arg <= pwdata_i[1:0];
        msn_pkg::OFF_LIM_A:
        begin
          lim[msn_pkg::TMR_TX] <= pwdata_i[15:0];
          lim[msn_pkg::TMR_NEG] <= pwdata_i[31:16];
        end
        msn_pkg::OFF_LIM_B:
        begin
          lim[msn_pkg::TMR_SYNC] <= pwdata_i[15:0];
          lim[msn_pkg::TMR_NC] <= pwdata_i[31:16];
        end
        msn_pkg::OFF_DELAY:
        begin
          dly_min <= pwdata_i[15:0];
          dly_max <= pwdata_i[31:16];
        end
        default: ;
      endcase
  end

  // Status word assembly
  always_comb
  begin
    status = 32'h0000_0000;
    status[msn_pkg::ST_STATE +: 3] = state;
    status[msn_pkg::ST_FAILED +: 4] = 4'(failed);
    status[msn_pkg::ST_PASS +: 4] = 4'(mon_pass);
    status[msn_pkg::ST_DONE] = test_done;
    status[msn_pkg::ST_RESULT] = test_pass;
    status[msn_pkg::ST_ATOM_LATE] = atom_late;
    status[msn_pkg::ST_EXPIRED +: 4] = next_expired;
    status[msn_pkg::ST_RECORDED +: 4] = recorded;
    status[msn_pkg::ST_ENABLE +: 4] = 4'(lane_enable_o);
  end

  // Read data captured in the setup phase
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      prdata_o <= 32'h0000_0000;
    else if (rd)
      case (paddr_i)
        msn_pkg::OFF_CTRL: prdata_o <= ctrl;
        msn_pkg::OFF_STATUS: prdata_o <= status;
        msn_pkg::OFF_SPEED: prdata_o <= {24'h00_0000, supported,
          tx_list & supported};
        msn_pkg::OFF_QUERY: prdata_o <= {26'h000_0000,
          next_lower(query_arg, supported),
          next_lower(query_arg, tx_list & supported),
          query_arg};
        msn_pkg::OFF_LIM_A: prdata_o <= {lim[msn_pkg::TMR_NEG],
          lim[msn_pkg::TMR_TX]};
        msn_pkg::OFF_LIM_B: prdata_o <= {lim[msn_pkg::TMR_NC],
          lim[msn_pkg::TMR_SYNC]};
        msn_pkg::OFF_DELAY: prdata_o <= {dly_max, dly_min};
        default: prdata_o <= 32'h0000_0000;
      endcase
  end
endmodule : multilane_speed_negotiation

// [verilog/sync_pass_monitor.sv]
// Per-lane sync pass test: back-to-back monitoring windows.
// Assumes word strobes and sync flags synchronous to clk_i.
`timescale 1ns/1ns
module sync_pass_monitor #(
  parameter int REQ_WORDS = 64,
  parameter int WIN_CYC = msn_pkg::MONITOR_MAX_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Lane receive status
  input wire logic word_i,
  input wire logic sync_i,
  input wire logic cv_i,
  input wire logic cv_count_i,
  // Result
  output logic pass_o,
  output logic done_o
);
  logic [15:0] consec;
  logic [15:0] win;
  logic cv_seen;
  logic reached;
  logic win_end;

  // Enough consecutive synchronized words, or the window ran out
  assign reached = consec >= 16'(REQ_WORDS);
  assign win_end = reached || (win >= 16'(WIN_CYC - 1));

  // Consecutive word count, restarted by loss of sync
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      consec <= 16'h0000;
    else if (win_end || !sync_i)
      consec <= 16'h0000;
    else if (word_i)
      consec <= consec + 16'h0001;
  end

  // Window length, never beyond the monitoring limit
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      win <= 16'h0000;
    else if (win_end)
      win <= 16'h0000;
    else
      win <= win + 16'h0001;
  end

  // Code violations seen in this window
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      cv_seen <= 1'b0;
    else if (win_end)
      cv_seen <= 1'b0;
    else if (cv_i && cv_count_i)
      cv_seen <= 1'b1;
  end

  // Window verdict, any counted violation fails it
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pass_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= win_end;
      if (win_end)
        pass_o <= reached && sync_i && !cv_seen
          && !(cv_i && cv_count_i);
    end
  end
endmodule : sync_pass_monitor
